/* logic/etc_pkg.sv */
// Package for the enhanced timer compare block: register map, fields, modes.
// Assumes a 32-bit APB slave with one register per aligned word.
package etc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL0 = 8'h00; // Run bit, period bits
    localparam logic [7:0] OFS_CTRL1 = 8'h04; // Channel A control, clear source
    localparam logic [7:0] OFS_CHB = 8'h08;   // timer1_channel_b_control
    localparam logic [7:0] OFS_CMPA = 8'h0c;  // compare_value_a
    localparam logic [7:0] OFS_CMPB = 8'h10;  // compare_value_b
    localparam logic [7:0] OFS_STAT = 8'h14;  // Match flags, write one to clear
    localparam logic [7:0] OFS_CNT = 8'h18;   // Counter readback
    // Reset values
    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam logic [9:0] RST_CMP = 10'h000;
    // Field positions
    localparam int CTRL0_RUN_BIT = 3;
    localparam int CTRL1_CCLR_BIT = 0;
    localparam int STAT_A_BIT = 0;
    localparam int STAT_B_BIT = 1;
    localparam int STAT_P_BIT = 2;
    // Counter geometry
    localparam int CNT_W = 10;
    localparam int PER_LSB = 7;
    // Channel mode codes
    typedef enum logic [1:0] {
        ETC_MODE_CMP = 2'h0,
        ETC_MODE_CAP = 2'h1,
        ETC_MODE_PWM = 2'h2,
        ETC_MODE_TMR = 2'h3
    } etc_mode_t;
    // Channel B control layout
    typedef struct packed {
        logic [1:0] chan_b_mode_sel;
        logic [1:0] chan_b_out_func;
        logic chan_b_out_level;
        logic chan_b_out_invert;
        logic [1:0] pwm_align_sel;
    } etc_chb_t;
    // Channel A control layout
    typedef struct packed {
        logic chan_a_mode_hi;
        logic chan_a_mode_lo;
        logic [1:0] chan_a_out_func;
        logic chan_a_out_level;
        logic chan_a_out_invert;
        logic count_down;
        logic clear_source_sel;
    } etc_cha_t;
    // Match event bundle
    typedef struct packed {
        logic match_p;
        logic match_b;
        logic match_a;
    } etc_match_t;
endpackage

/* logic/etc_out_chan.sv */
`timescale 1ns/1ps
// One compare-mode output channel: pin state, restore, match action, polarity.
// Assumes match strobes and run-bit rise arrive on pclk.
module etc_out_chan
    import etc_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic [1:0] mode,
    input wire logic [1:0] out_func,
    input wire logic out_level,
    input wire logic out_invert,
    input wire logic run_rise,
    input wire logic match,
    // Pin
    output logic pin
);
    logic pin_ff; // Raw pin level before polarity
    logic nxt_pin;

    // Next raw level: restore on start, else apply the match action
    always_comb begin
        nxt_pin = pin_ff;
        if (run_rise) begin
            nxt_pin = out_level;
        end else if (match && mode == ETC_MODE_CMP) begin
            case (out_func)
                2'h0: nxt_pin = pin_ff;
                2'h1: nxt_pin = 1'b0;
                2'h2: nxt_pin = 1'b1;
                2'h3: nxt_pin = ~pin_ff;
                default: nxt_pin = pin_ff;
            endcase
        end
    end

    // Register the raw level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_ff <= 1'b0;
        end else begin
            pin_ff <= nxt_pin;
        end
    end

    // Timer/counter mode never drives the pin, so polarity is moot there
    assign pin = (mode == ETC_MODE_TMR) ? 1'b0 : (pin_ff ^ out_invert);

    a_restore_level: assert property (@(posedge pclk) disable iff (!presetn)
        run_rise |=> pin_ff == $past(out_level)) else $error("pin not restored");
    a_match_low: assert property (@(posedge pclk) disable iff (!presetn)
        (match && !run_rise && mode == ETC_MODE_CMP && out_func == 2'h1) |=> !pin_ff)
        else $error("drive low missed");
    a_hold_nomatch: assert property (@(posedge pclk) disable iff (!presetn)
        (!match && !run_rise) |=> $stable(pin_ff)) else $error("pin moved");
endmodule

/* logic/etc_timer.sv */
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
// Enhanced 10-bit timer, compare-match output path with channel B control.
// Assumes an APB master on pclk; counter ticks every pclk.
//
// Contract
// - Channel B mode field selects operating mode
// - Compare mode match: none, low, high, toggle
// - PWM mode codes: inactive, active, PWM, pulse; here codes PWM and pulse only raise chan_b_pwm_active, pin B keeps its level
// - Capture mode codes select edge or disable
// - No change when requested equals initial
// - Run bit rise restores initial pin level
// - Level bit: initial or active level
// - Polarity bit inverts pin except timer mode
// - Alignment field selects edge or centre; here it is only stored and read back
// - Clear select low: P match clears, flags A,P
// - Clear select high: A clears, no P
// - Only A or B matches move pins
// - Pin A follows A flag, B follows B
// - Run rise zeroes counter, fall holds it
// - Period bits compare counter bits 9..7; zero compares all ones
// - Comparator B never clears counter
module etc_timer
    import etc_pkg::*;
(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Output pins
    output logic chan_a_out_pin,
    output logic chan_b_out_pin,
    // Status for the system
    output logic [2:0] match_flags,
    output logic [1:0] chan_b_capture_edge,
    output logic chan_b_pwm_active
);
    // Register state
    logic [7:0] ctrl0_ff, nxt_ctrl0; // Run bit and period bits
    etc_cha_t cha_ff, nxt_cha; // Channel A control
    etc_chb_t chb_ff, nxt_chb; // Channel B control
    logic [9:0] cmpa_ff, nxt_cmpa;
    logic [9:0] cmpb_ff, nxt_cmpb;
    etc_match_t flag_ff, nxt_flag; // Sticky match flags
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic run_d_ff, nxt_run_d; // Run bit one cycle late, for edge detect
    logic [31:0] prdata_ff, nxt_prdata;

    logic wr_en, rd_en, addr_ok;
    logic run_bit, run_rise;
    logic [2:0] period_bits;
    etc_match_t hit;
    logic at_top;
    etc_mode_t mode_b;

    assign run_bit = ctrl0_ff[CTRL0_RUN_BIT];
    assign period_bits = ctrl0_ff[2:0];
    assign run_rise = run_bit && !run_d_ff;
    assign mode_b = etc_mode_t'(chb_ff.chan_b_mode_sel);

    // Zero-wait APB: every access completes in its access phase
    assign pready = 1'b1;
    assign addr_ok = (paddr == OFS_CTRL0) || (paddr == OFS_CTRL1) || (paddr == OFS_CHB) ||
                     (paddr == OFS_CMPA) || (paddr == OFS_CMPB) || (paddr == OFS_STAT) ||
                     (paddr == OFS_CNT);
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en = psel && penable && pwrite && addr_ok;
    assign rd_en = psel && !penable && !pwrite;
    assign prdata = prdata_ff;

    // Comparators; period compares the whole count with the period bits over seven zero bits, or with all ones when the period bits are zero
    always_comb begin
        // The start cycle still sees the count left by the last stop, so it
        // must not compare; the counter is being zeroed in that cycle
        at_top = (cnt_ff == {CNT_W{1'b1}});
        hit.match_a = run_bit && !run_rise && (cnt_ff == cmpa_ff);
        hit.match_b = run_bit && !run_rise && (cnt_ff == cmpb_ff);
        if (period_bits == 3'h0) begin
            hit.match_p = run_bit && !run_rise && at_top;
        end else begin
            hit.match_p = run_bit && !run_rise && (cnt_ff == {period_bits, 7'h00});
        end
        // With A as clear source the P event is suppressed entirely
        if (cha_ff.clear_source_sel) begin
            hit.match_p = 1'b0;
        end
    end

    // Counter next state
    always_comb begin
        nxt_run_d = run_bit;
        nxt_cnt = cnt_ff;
        if (run_rise) begin
            nxt_cnt = '0;
        end else if (run_bit) begin
            if (cha_ff.clear_source_sel ? hit.match_a : hit.match_p) begin
                nxt_cnt = '0;
            end else begin
                nxt_cnt = cnt_ff + 10'h001;
            end
        end
    end

    // Register and flag next state; hardware set wins over software clear
    always_comb begin
        nxt_ctrl0 = ctrl0_ff;
        nxt_cha = cha_ff;
        nxt_chb = chb_ff;
        nxt_cmpa = cmpa_ff;
        nxt_cmpb = cmpb_ff;
        nxt_flag = flag_ff;
        if (wr_en) begin
            case (paddr)
                OFS_CTRL0: nxt_ctrl0 = pwdata[7:0];
                OFS_CTRL1: nxt_cha = etc_cha_t'({pwdata[7:2], cha_ff.count_down, pwdata[0]});
                OFS_CHB: nxt_chb = etc_chb_t'(pwdata[7:0]);
                OFS_CMPA: nxt_cmpa = pwdata[9:0];
                OFS_CMPB: nxt_cmpb = pwdata[9:0];
                OFS_STAT: nxt_flag = etc_match_t'(flag_ff & ~pwdata[2:0]);
                default: nxt_flag = nxt_flag;
            endcase
        end
        nxt_flag = etc_match_t'(nxt_flag | hit);
    end

    // Read data captured in the setup phase
    always_comb begin
        nxt_prdata = prdata_ff;
        if (rd_en) begin
            case (paddr)
                OFS_CTRL0: nxt_prdata = {24'h000000, ctrl0_ff};
                OFS_CTRL1: nxt_prdata = {24'h000000, cha_ff};
                OFS_CHB: nxt_prdata = {24'h000000, chb_ff};
                OFS_CMPA: nxt_prdata = {22'h000000, cmpa_ff};
                OFS_CMPB: nxt_prdata = {22'h000000, cmpb_ff};
                OFS_STAT: nxt_prdata = {29'h00000000, flag_ff};
                OFS_CNT: nxt_prdata = {22'h000000, cnt_ff};
                default: nxt_prdata = 32'h00000000;
            endcase
        end
    end

    // State registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl0_ff <= RST_REG8;
            cha_ff <= etc_cha_t'(RST_REG8);
            chb_ff <= etc_chb_t'(RST_REG8);
            cmpa_ff <= RST_CMP;
            cmpb_ff <= RST_CMP;
            flag_ff <= etc_match_t'(3'h0);
            cnt_ff <= RST_CMP;
            run_d_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else begin
            ctrl0_ff <= nxt_ctrl0;
            cha_ff <= nxt_cha;
            chb_ff <= nxt_chb;
            cmpa_ff <= nxt_cmpa;
            cmpb_ff <= nxt_cmpb;
            flag_ff <= nxt_flag;
            cnt_ff <= nxt_cnt;
            run_d_ff <= nxt_run_d;
            prdata_ff <= nxt_prdata;
        end
    end

    assign match_flags = flag_ff;
    // Capture edge code passed on for the capture path
    assign chan_b_capture_edge = (mode_b == ETC_MODE_CAP) ? chb_ff.chan_b_out_func : 2'h3;
    // PWM enable level for the waveform path
    assign chan_b_pwm_active = (mode_b == ETC_MODE_PWM) && chb_ff.chan_b_out_func[1];

    // Output channels; each listens only to its own comparator
    etc_out_chan u_chan_a (
        .pclk(pclk),
        .presetn(presetn),
        .mode({cha_ff.chan_a_mode_hi, cha_ff.chan_a_mode_lo}),
        .out_func(cha_ff.chan_a_out_func),
        .out_level(cha_ff.chan_a_out_level),
        .out_invert(cha_ff.chan_a_out_invert),
        .run_rise(run_rise),
        .match(hit.match_a),
        .pin(chan_a_out_pin)
    );
    etc_out_chan u_chan_b (
        .pclk(pclk),
        .presetn(presetn),
        .mode(chb_ff.chan_b_mode_sel),
        .out_func(chb_ff.chan_b_out_func),
        .out_level(chb_ff.chan_b_out_level),
        .out_invert(chb_ff.chan_b_out_invert),
        .run_rise(run_rise),
        .match(hit.match_b),
        .pin(chan_b_out_pin)
    );

    a_run_rise_zero: assert property (@(posedge pclk) disable iff (!presetn)
        run_rise |=> cnt_ff == 10'h000) else $error("counter not zeroed");
    a_stop_holds: assert property (@(posedge pclk) disable iff (!presetn)
        (!run_bit && !run_d_ff) |=> $stable(cnt_ff)) else $error("counter moved");
    a_no_p_flag: assert property (@(posedge pclk) disable iff (!presetn)
        cha_ff.clear_source_sel |-> !hit.match_p) else $error("P with A clear");
    a_p_clears: assert property (@(posedge pclk) disable iff (!presetn)
        (run_bit && !run_rise && !cha_ff.clear_source_sel && hit.match_p) |=>
        cnt_ff == 10'h000 && flag_ff.match_p) else $error("P clear missed");
    a_a_clears: assert property (@(posedge pclk) disable iff (!presetn)
        (run_bit && !run_rise && cha_ff.clear_source_sel && hit.match_a) |=>
        cnt_ff == 10'h000 && flag_ff.match_a) else $error("A clear missed");
    a_b_no_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (run_bit && !run_rise && hit.match_b && !hit.match_a && !hit.match_p &&
        cnt_ff != 10'h3ff) |=> cnt_ff == $past(cnt_ff) + 10'h001)
        else $error("B cleared counter");
    a_b_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        (run_bit && !run_rise && cnt_ff == cmpb_ff) |=> flag_ff.match_b)
        else $error("B flag lost");
    a_period_top: assert property (@(posedge pclk) disable iff (!presetn)
        (run_bit && !cha_ff.clear_source_sel && period_bits != 3'h0 &&
        cnt_ff[9:7] == period_bits && cnt_ff[6:0] == 7'h00) |-> hit.match_p)
        else $error("period compare");
endmodule

/* testbench/tb_etc_timer.sv */
// Testbench for the enhanced timer: APB registers, channel B pin, counter clear.
// Assumes the APB slave answers in its access phase and the counter ticks every pclk.
`timescale 1ns/1ps
module tb_etc_timer
    import etc_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite; // APB side
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, r, c1; // Bus data and scratch
    logic pready, pslverr, err, pin_a, pin_b, pwm_act, lvl, inv, alvl;
    logic [2:0] flags;
    logic [1:0] cap_edge, f;
    logic [7:0] v;
    int num_errors, checks, cycles, seed;

    // Free-running 50 MHz clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    etc_timer u_etc_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chan_a_out_pin(pin_a), .chan_b_out_pin(pin_b),
        .match_flags(flags), .chan_b_capture_edge(cap_edge), .chan_b_pwm_active(pwm_act));

    task automatic give_verdict();
        if (num_errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Expected pin: raw level from level bit, changed once by a match, then polarity
    function automatic logic exp_pin(input logic [1:0] fn, input logic l, input logic i,
        input logic hit);
        logic raw;
        raw = l;
        if (hit) begin
            case (fn)
                2'h1: raw = 1'b0;
                2'h2: raw = 1'b1;
                2'h3: raw = ~l;
                default: raw = l;
            endcase
        end
        return raw ^ i;
    endfunction

    // Hang guard; the sequence needs under two thousand cycles
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {num_errors, checks, cycles} = '0;
        seed = 36;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        // Every register comes out of reset as zero
        for (int a = 0; a <= 'h18; a += 4) begin
            apb(1'b0, a[7:0], 32'h0);
            chk(rd, 32'h0);
        end
        // Unmapped place is refused and reads zero
        apb(1'b1, 8'h40, 32'hffffffff);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        // Every mode and function code, random level, polarity and alignment
        for (int i = 0; i < 16; i++) begin
            r = $random(seed);
            v = {i[3:0], r[3:0]};
            apb(1'b1, OFS_CHB, {24'h0, v});
            apb(1'b0, OFS_CHB, 32'h0);
            chk(rd, {24'h0, v});
            chk({30'h0, cap_edge}, {30'h0, (v[7:6] == 2'h1) ? v[5:4] : 2'h3});
            chk({31'h0, pwm_act}, {31'h0, v[7:6] == 2'h2 && v[5]});
        end
        // Compare mode: restore on run rise, then one B match action
        apb(1'b1, OFS_CMPA, 32'h3ff);
        for (int i = 0; i < 12; i++) begin
            r = $random(seed);
            f = i[1:0];
            {alvl, inv, lvl} = r[6:4];
            apb(1'b1, OFS_CTRL0, 32'h0);
            apb(1'b1, OFS_STAT, 32'h7);
            apb(1'b1, OFS_CTRL1, {28'h0, alvl, 3'h0});
            apb(1'b1, OFS_CHB, {26'h0, f, lvl, inv, 2'h0});
            apb(1'b1, OFS_CMPB, {27'h0, r[11:7]} + 32'h10);
            apb(1'b1, OFS_CTRL0, 32'h8);
            repeat (2) @(posedge pclk);
            chk({31'h0, pin_b}, {31'h0, exp_pin(f, lvl, inv, 1'b0)});
            for (int n = 0; n < 100 && flags[1] !== 1'b1; n++) @(posedge pclk);
            repeat (2) @(posedge pclk);
            chk({31'h0, pin_b}, {31'h0, exp_pin(f, lvl, inv, 1'b1)});
            chk({31'h0, pin_a}, {31'h0, alvl});
            chk({29'h0, flags}, 32'h2);
        end
        // Timer/counter mode never drives the pin
        apb(1'b1, OFS_CTRL0, 32'h0);
        apb(1'b1, OFS_CTRL1, 32'hc0);
        apb(1'b1, OFS_CHB, 32'hcc);
        apb(1'b1, OFS_CTRL0, 32'h8);
        repeat (2) @(posedge pclk);
        chk({31'h0, pin_b}, 32'h0);
        // Clear on A, then on P at period 128: A flag only, then A and P flags; B beyond never hit
        for (int k = 0; k < 2; k++) begin
            c1 = (k == 0) ? 32'h1 : 32'h0;
            apb(1'b1, OFS_CTRL0, 32'h0);
            apb(1'b1, OFS_STAT, 32'h7);
            apb(1'b1, OFS_CTRL1, c1);
            apb(1'b1, OFS_CHB, 32'h0);
            apb(1'b1, OFS_CMPA, 32'h3c);
            apb(1'b1, OFS_CMPB, 32'hc8);
            apb(1'b1, OFS_CTRL0, 32'h9);
            repeat (300) @(posedge pclk);
            chk({29'h0, flags}, (k == 0) ? 32'h1 : 32'h5);
            apb(1'b0, OFS_CNT, 32'h0);
            chk({31'h0, rd <= ((k == 0) ? 32'h3c : 32'h80)}, 32'h1);
        end
        // Stopping holds the count; run rise restarts from zero
        apb(1'b1, OFS_CTRL0, 32'h1);
        apb(1'b0, OFS_CNT, 32'h0);
        r = rd;
        repeat (20) @(posedge pclk);
        apb(1'b0, OFS_CNT, 32'h0);
        chk(rd, r);
        apb(1'b1, OFS_CTRL0, 32'h9);
        apb(1'b0, OFS_CNT, 32'h0);
        chk({31'h0, rd < 32'h8}, 32'h1);
        give_verdict();
    end
endmodule
